// [logic/sar_adc_sequencer.sv]
// digital control of a 12-bit successive-approximation converter
// Overview of operation
// - writing start with enable begins conversion
// - start bit self-clears at conversion end unless pwm trigger active
// - end sets done, irq flag, loads result
// - flag with irq enable raises request
// - irq flag clears when interrupt serviced
// - pwm trigger converts continuously while pwm on
// - codes 0..11 route external inputs
// - codes 24..26 route opamps and level
// - channel connects only if gate set at conversion start
// - mask bit isolates digital path of pin
// - internal high reference level decode
// - external low and high reference select
// - clock select divides oscillator clock
// - conversion lasts 64 converter clocks
// - result split high byte, low nibble
// - result read-only, zero until first
// - result straight binary, 4096 steps
// - runs idle; completion with irq enable wakes from green
// - done set by hardware, cleared by zero
// - enable bit seven powers converter
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"
module sar_adc_sequencer (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [11:0] core_result,
    input wire logic pwm_unit1_enable,
    input wire logic irq_serviced,
    input wire logic green_mode,
    output logic core_power,
    output logic core_sample,
    output logic core_clk_tick,
    output sar_pkg::route_type route,
    output logic [7:0] port2_analog_mask,
    output logic [7:0] port3_analog_mask,
    output logic [7:0] port4_analog_mask,
    output logic [7:0] port5_analog_mask,
    output logic irq_req,
    output logic wake_req
);
    logic [1:0] pwm_sync_ff;
    logic pwm_on;
    logic converter_enable_ff, nxt_converter_enable;
    logic conversion_start_ff, nxt_conversion_start;
    logic done_ff, nxt_done;
    logic [4:0] input_channel_code_ff, nxt_input_channel_code;
    logic channel_gate_ff, nxt_channel_gate;
    logic [1:0] converter_clock_select_ff, nxt_converter_clock_select;
    logic [7:0] ref_ff, nxt_ref;
    logic [7:0] p2_ff, nxt_p2, p3_ff, nxt_p3, p4_ff, nxt_p4, p5_ff, nxt_p5;
    logic irq_en_ff, nxt_irq_en;
    logic irq_flag_ff, nxt_irq_flag;
    logic [11:0] result_ff, nxt_result;
    logic [7:0] rdata_ff, nxt_rdata;
    sar_pkg::state_type state_ff, nxt_state;
    logic [3:0] div_ff, nxt_div;
    logic [6:0] cnt_ff, nxt_cnt;
    logic [1:0] held_cks_ff, nxt_held_cks;
    sar_pkg::route_type route_ff, nxt_route;
    logic tick_ff, nxt_tick;
    logic sample_ff, nxt_sample;
    logic irq_req_ff, nxt_irq_req;
    logic wake_ff, nxt_wake;
    logic finish, trig;

    // clock select to divide ratio minus one
    function automatic logic [3:0] div_last(input logic [1:0] cks);
        unique case (cks)
            2'b00: div_last = 4'hf;
            2'b01: div_last = 4'h7;
            2'b10: div_last = 4'h0;
            2'b11: div_last = 4'h1;
        endcase
    endfunction

    // channel code and references to analog routing
    function automatic sar_pkg::route_type decode_route(
        input logic [4:0] code, input logic gate, input logic [7:0] rf);
        sar_pkg::route_type r;
        r = '0;
        r.ext_hi = rf[`BIT_EXT_HI];
        r.ext_lo = rf[`BIT_EXT_LO];
        r.hi_level = rf[1:0];
        r.vdd_force = rf[`BIT_VHS2];
        r.ext_index = code[3:0];
        if (code <= `CH_LAST_EXT)
        begin
            r.connect = gate;
            r.kind = sar_pkg::sel_ext;
        end
        else if (code == `CH_OPAMP0)
        begin
            r.connect = gate;
            r.kind = sar_pkg::sel_opamp0;
        end
        else if (code == `CH_OPAMP1)
        begin
            r.connect = gate;
            r.kind = sar_pkg::sel_opamp1;
        end
        else if (code == `CH_LEVEL)
        begin
            r.connect = gate;
            r.kind = sar_pkg::sel_level;
        end
        return r;
    endfunction

    // pwm enable is from another block, two stages
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pwm_sync_ff <= 2'b00;
        else if (clk_en)
            pwm_sync_ff <= {pwm_sync_ff[0], pwm_unit1_enable};
    end
    assign pwm_on = pwm_sync_ff[1];

    assign finish = state_ff == sar_pkg::st_conv && tick_ff
        && cnt_ff == `CONV_CLOCKS - 7'd1;
    assign trig = ref_ff[`BIT_PWM_TRIG] && pwm_on;

    always_comb
    begin
        nxt_converter_enable = converter_enable_ff;
        nxt_conversion_start = conversion_start_ff;
        nxt_done = done_ff;
        nxt_input_channel_code = input_channel_code_ff;
        nxt_channel_gate = channel_gate_ff;
        nxt_converter_clock_select = converter_clock_select_ff;
        nxt_ref = ref_ff;
        nxt_p2 = p2_ff;
        nxt_p3 = p3_ff;
        nxt_p4 = p4_ff;
        nxt_p5 = p5_ff;
        nxt_irq_en = irq_en_ff;
        nxt_irq_flag = irq_flag_ff;
        nxt_result = result_ff;
        nxt_rdata = 8'h00;
        nxt_state = state_ff;
        nxt_div = div_ff;
        nxt_cnt = cnt_ff;
        nxt_held_cks = held_cks_ff;
        nxt_route = route_ff;
        nxt_tick = 1'b0;
        nxt_sample = 1'b0;
        if (reg_wr)
        begin
            unique case (reg_addr)
                `OFS_MODE:
                begin
                    nxt_converter_enable = reg_wdata[`BIT_ENABLE];
                    if (reg_wdata[`BIT_START] && reg_wdata[`BIT_ENABLE])
                        nxt_conversion_start = 1'b1;
                    else if (!reg_wdata[`BIT_START])
                        nxt_conversion_start = 1'b0;
                    if (!reg_wdata[`BIT_DONE])
                        nxt_done = 1'b0;
                    nxt_input_channel_code = reg_wdata[4:0];
                end
                `OFS_RES_LO:
                begin
                    nxt_channel_gate = reg_wdata[`BIT_GATE];
                    nxt_converter_clock_select = reg_wdata[5:4];
                end
                `OFS_REF: nxt_ref = reg_wdata & 8'hd7;
                `OFS_P2MASK: nxt_p2 = reg_wdata & 8'hf0;
                `OFS_P3MASK: nxt_p3 = reg_wdata;
                `OFS_P4MASK: nxt_p4 = reg_wdata;
                `OFS_P5MASK: nxt_p5 = reg_wdata & 8'h3f;
                `OFS_INTERRUPT_ENABLE_TWO: nxt_irq_en = reg_wdata[`BIT_IRQ_EN];
                `OFS_IRQ2:
                    if (!reg_wdata[`BIT_IRQ_FLAG])
                        nxt_irq_flag = 1'b0;
                default: ;
            endcase
        end
        if (irq_serviced)
            nxt_irq_flag = 1'b0;
        if (!nxt_converter_enable)
            nxt_conversion_start = 1'b0;
        unique case (state_ff)
            sar_pkg::st_idle:
                if (converter_enable_ff && (conversion_start_ff || trig))
                begin
                    nxt_state = sar_pkg::st_conv;
                    nxt_conversion_start = 1'b1;
                    nxt_held_cks = converter_clock_select_ff;
                    nxt_route = decode_route(input_channel_code_ff,
                        channel_gate_ff, ref_ff);
                    nxt_div = 4'h0;
                    nxt_cnt = 7'd0;
                    nxt_sample = 1'b1;
                end
            sar_pkg::st_conv:
            begin
                if (!converter_enable_ff)
                    nxt_state = sar_pkg::st_idle;
                else if (finish)
                begin
                    nxt_state = sar_pkg::st_idle;
                    nxt_conversion_start = trig;
                    nxt_done = 1'b1;
                    nxt_irq_flag = 1'b1;
                    nxt_result = core_result;
                end
                else if (tick_ff)
                    nxt_cnt = cnt_ff + 7'd1;
                if (div_ff == div_last(held_cks_ff))
                begin
                    nxt_div = 4'h0;
                    nxt_tick = !finish;
                end
                else
                    nxt_div = div_ff + 4'h1;
            end
        endcase
        if (!converter_enable_ff)
            nxt_route.connect = 1'b0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `OFS_MODE: nxt_rdata = {converter_enable_ff,
                    conversion_start_ff, done_ff, input_channel_code_ff};
                `OFS_RES_HI: nxt_rdata = result_ff[11:4];
                `OFS_RES_LO: nxt_rdata = {1'b0, channel_gate_ff,
                    converter_clock_select_ff, result_ff[3:0]};
                `OFS_REF: nxt_rdata = ref_ff;
                `OFS_P2MASK: nxt_rdata = p2_ff;
                `OFS_P3MASK: nxt_rdata = p3_ff;
                `OFS_P4MASK: nxt_rdata = p4_ff;
                `OFS_P5MASK: nxt_rdata = p5_ff;
                `OFS_INTERRUPT_ENABLE_TWO: nxt_rdata = {4'h0, irq_en_ff, 3'h0};
                `OFS_IRQ2: nxt_rdata = {5'h00, irq_flag_ff, 2'b00};
                default: nxt_rdata = 8'h00;
            endcase
        end
        nxt_irq_req = irq_en_ff && irq_flag_ff;
        nxt_wake = irq_en_ff && finish && green_mode;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            converter_enable_ff <= 1'b0;
            conversion_start_ff <= 1'b0;
            done_ff <= 1'b0;
            input_channel_code_ff <= 5'h00;
            channel_gate_ff <= 1'b0;
            converter_clock_select_ff <= 2'b00;
            ref_ff <= 8'h00;
            p2_ff <= `MASK_RESET;
            p3_ff <= `MASK_RESET;
            p4_ff <= `MASK_RESET;
            p5_ff <= `MASK_RESET;
            irq_en_ff <= 1'b0;
            irq_flag_ff <= 1'b0;
            result_ff <= 12'h000;
            rdata_ff <= 8'h00;
            state_ff <= sar_pkg::st_idle;
            div_ff <= 4'h0;
            cnt_ff <= 7'd0;
            held_cks_ff <= 2'b00;
            route_ff <= '0;
            tick_ff <= 1'b0;
            sample_ff <= 1'b0;
            irq_req_ff <= 1'b0;
            wake_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            converter_enable_ff <= nxt_converter_enable;
            conversion_start_ff <= nxt_conversion_start;
            done_ff <= nxt_done;
            input_channel_code_ff <= nxt_input_channel_code;
            channel_gate_ff <= nxt_channel_gate;
            converter_clock_select_ff <= nxt_converter_clock_select;
            ref_ff <= nxt_ref;
            p2_ff <= nxt_p2;
            p3_ff <= nxt_p3;
            p4_ff <= nxt_p4;
            p5_ff <= nxt_p5;
            irq_en_ff <= nxt_irq_en;
            irq_flag_ff <= nxt_irq_flag;
            result_ff <= nxt_result;
            rdata_ff <= nxt_rdata;
            state_ff <= nxt_state;
            div_ff <= nxt_div;
            cnt_ff <= nxt_cnt;
            held_cks_ff <= nxt_held_cks;
            route_ff <= nxt_route;
            tick_ff <= nxt_tick;
            sample_ff <= nxt_sample;
            irq_req_ff <= nxt_irq_req;
            wake_ff <= nxt_wake;
        end
    end

    assign reg_rdata = rdata_ff;
    assign core_power = converter_enable_ff;
    assign core_sample = sample_ff;
    assign core_clk_tick = tick_ff;
    assign route = route_ff;
    assign port2_analog_mask = p2_ff;
    assign port3_analog_mask = p3_ff;
    assign port4_analog_mask = p4_ff;
    assign port5_analog_mask = p5_ff;
    assign irq_req = irq_req_ff;
    assign wake_req = wake_ff;

    property p_done_sets_flags;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && finish) |=> (done_ff && irq_flag_ff);
    endproperty
    a_done_sets_flags: assert property (p_done_sets_flags)
        else $error("done without flags");

    property p_start_clears;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && finish && !trig) |=> !conversion_start_ff;
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("start bit not cleared");

    property p_ignored_start;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && !converter_enable_ff && state_ff == sar_pkg::st_idle)
            |=> state_ff == sar_pkg::st_idle;
    endproperty
    a_ignored_start: assert property (p_ignored_start)
        else $error("conversion while disabled");

    property p_irq_follows;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && irq_en_ff && irq_flag_ff) |=> irq_req_ff;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("irq request missing");

    property p_service_clears;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && irq_serviced && !finish) |=> !irq_flag_ff;
    endproperty
    a_service_clears: assert property (p_service_clears)
        else $error("flag not cleared on service");

    property p_result_loaded;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && finish) |=> result_ff == $past(core_result);
    endproperty
    a_result_loaded: assert property (p_result_loaded)
        else $error("result not loaded");

    property p_held_cks;
        @(posedge clk) disable iff (!reset_n)
        (state_ff == sar_pkg::st_conv && $past(state_ff)
            == sar_pkg::st_conv) |-> $stable(held_cks_ff);
    endproperty
    a_held_cks: assert property (p_held_cks)
        else $error("clock select changed mid conversion");

    property p_count_bound;
        @(posedge clk) disable iff (!reset_n)
        cnt_ff < `CONV_CLOCKS;
    endproperty
    a_count_bound: assert property (p_count_bound)
        else $error("conversion count overrun");

    property p_fast_clock;
        @(posedge clk) disable iff (!reset_n)
        (state_ff == sar_pkg::st_conv && held_cks_ff == 2'b10 && clk_en
            && !finish && converter_enable_ff) |=> tick_ff;
    endproperty
    a_fast_clock: assert property (p_fast_clock)
        else $error("undivided clock missed a tick");
endmodule
`default_nettype wire

// [common/sar_consts.svh]
// register offsets, field positions, reset values and timing counts
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH
`define OFS_MODE 8'hd2
`define OFS_RES_HI 8'hd3
`define OFS_RES_LO 8'hd4
`define OFS_REF 8'hd5
`define OFS_P4MASK 8'hd6
`define OFS_P5MASK 8'hd7
`define OFS_P2MASK 8'h9e
`define OFS_P3MASK 8'h9f
`define OFS_INTERRUPT_ENABLE_TWO 8'h9a
`define OFS_IRQ2 8'hbf
`define BIT_ENABLE 7
`define BIT_START 6
`define BIT_DONE 5
`define BIT_GATE 6
`define BIT_EXT_HI 7
`define BIT_EXT_LO 6
`define BIT_PWM_TRIG 4
`define BIT_VHS2 2
`define BIT_IRQ_EN 3
`define BIT_IRQ_FLAG 2
`define CONV_CLOCKS 7'd64
`define MASK_RESET 8'h00
`define CH_OPAMP0 5'h18
`define CH_OPAMP1 5'h19
`define CH_LEVEL 5'h1a
`define CH_LAST_EXT 5'h0b
`endif

// [common/sar_pkg.sv]
// types shared by the converter sequencer
package sar_pkg;
    typedef enum logic [1:0] {sel_ext, sel_opamp0, sel_opamp1, sel_level}
        src_kind_type;
    typedef struct packed {
        logic connect;
        src_kind_type kind;
        logic [3:0] ext_index;
        logic ext_hi;
        logic ext_lo;
        logic [1:0] hi_level;
        logic vdd_force;
    } route_type;
    typedef enum logic {st_idle, st_conv} state_type;
endpackage

// [testbench/analog_core_model.sv]
// behavioural model of the analog converter core
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
    input wire logic clk,
    input wire logic core_power,
    input wire logic core_sample,
    input wire logic core_clk_tick,
    input wire logic [11:0] level,
    output logic [11:0] core_result
);
    logic [11:0] held = 12'h000;
    logic [6:0] steps = 7'h00;
    // level taken at sample, settles over the converter clocks
    always @(posedge clk)
    begin
        if (core_sample)
        begin
            held <= level;
            steps <= 7'h00;
        end
        else if (core_clk_tick && steps != 7'h40)
        begin
            steps <= steps + 7'h01;
        end
    end
    // unsettled or unpowered: inverse of the held code
    assign core_result = (core_power && steps >= 7'h30) ? held : ~held;
endmodule
`default_nettype wire

// [testbench/sar_adc_sequencer_bench.sv]
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sar_consts.svh"
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module sar_adc_sequencer_bench;
    typedef struct {logic [4:0] code; logic gate; logic [1:0] sel;
        logic [7:0] rf; logic [11:0] lvl; logic grn;} case_type;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pwm_en = 1'b0;
    logic irq_serviced = 1'b0;
    logic green_mode = 1'b0;
    logic [11:0] level = 12'h000;
    logic [7:0] reg_rdata, m2, m3, m4, m5;
    logic [11:0] core_result;
    logic core_power, core_sample, core_clk_tick, irq_req, wake_req;
    sar_pkg::route_type route;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0, ticks = 0, first_t = 0, last_t = 0, samples = 0, wakes = 0;
    case_type tbl [6] = '{
        '{5'h05, 1'b1, 2'h0, 8'h00, 12'habc, 1'b0},
        '{5'h0b, 1'b1, 2'h1, 8'h43, 12'h000, 1'b1},
        '{5'h18, 1'b1, 2'h2, 8'h81, 12'hfff, 1'b0},
        '{5'h1a, 1'b1, 2'h3, 8'h06, 12'h5a5, 1'b0},
        '{5'h0c, 1'b1, 2'h2, 8'h02, 12'h123, 1'b0},
        '{5'h19, 1'b0, 2'h2, 8'h00, 12'h876, 1'b0}};
    int dv [4] = '{16, 8, 1, 2};
    logic [7:0] ma [4] = '{`OFS_P2MASK, `OFS_P3MASK, `OFS_P4MASK, `OFS_P5MASK};
    logic [7:0] mv [4] = '{8'h50, 8'ha5, 8'h3c, 8'h2a};
    wire logic [31:0] masks = {m2, m3, m4, m5};

    sar_adc_sequencer dut_u (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_result(core_result),
        .pwm_unit1_enable(pwm_en), .irq_serviced(irq_serviced),
        .green_mode(green_mode), .core_power(core_power),
        .core_sample(core_sample), .core_clk_tick(core_clk_tick),
        .route(route), .port2_analog_mask(m2), .port3_analog_mask(m3),
        .port4_analog_mask(m4), .port5_analog_mask(m5), .irq_req(irq_req),
        .wake_req(wake_req));
    analog_core_model core_u (.clk(clk), .core_power(core_power),
        .core_sample(core_sample), .core_clk_tick(core_clk_tick),
        .level(level), .core_result(core_result));

    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (core_clk_tick)
        begin
            ticks++;
            last_t = cyc;
            if (ticks == 1)
                first_t = cyc;
        end
        if (core_sample)
            samples++;
        if (wake_req)
            wakes++;
    end

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic clr();
        #1;
        ticks = 0;
        samples = 0;
        wakes = 0;
    endtask
    task automatic wait_ticks(int n);
        int k;
        k = 0;
        while (ticks < n && k < 3000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        if (ticks < n)
        begin
            `CHK("tick wait", n, ticks);
            end_of_test();
        end
    endtask

    initial
    begin
        logic [7:0] d;
        case_type t;
        logic conn;
        sar_pkg::src_kind_type kd;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        // reset state, unmapped place, masks
        for (int i = 0; i < 4; i++)
        begin
            rd(ma[i], d);
            `CHK("mask reset", 8'h00, d);
            wr(ma[i], mv[i]);
            rd(ma[i], d);
            `CHK("mask rw", mv[i], d);
            `CHK("mask pin", mv[i], masks[8*(3-i) +: 8]);
            wr(ma[i], 8'h00);
        end
        rd(8'h00, d);
        `CHK("unmapped", 8'h00, d);
        wr(`OFS_RES_HI, 8'hff);
        rd(`OFS_RES_HI, d);
        `CHK("result ro", 8'h00, d);
        // start while disabled
        clr();
        wr(`OFS_MODE, 8'h40);
        repeat (20) @(posedge clk);
        #1;
        `CHK("no sample", 0, samples);
        `CHK("power off", 1'b0, core_power);
        rd(`OFS_MODE, d);
        `CHK("mode idle", 8'h00, d);
        rd(`OFS_IRQ2, d);
        `CHK("no flag", 1'b0, d[2]);
        wr(`OFS_INTERRUPT_ENABLE_TWO, 8'h08);
        wr(`OFS_P4MASK, 8'h20);
        for (int i = 0; i < 6; i++)
        begin
            t = tbl[i];
            green_mode <= t.grn;
            level <= t.lvl;
            wr(`OFS_RES_LO, {1'b0, t.gate, t.sel, 4'h0});
            wr(`OFS_REF, t.rf);
            wr(`OFS_MODE, {3'b100, t.code});
            #1;
            `CHK("power on", 1'b1, core_power);
            clr();
            wr(`OFS_MODE, {3'b110, t.code});
            wait_ticks(5);
            `CHK("sample", 1, samples);
            wr(`OFS_RES_LO, {1'b0, ~t.gate, t.sel, 4'h0});
            wr(`OFS_REF, t.rf ^ 8'hc7);
            wait_ticks(64);
            repeat (3) @(posedge clk);
            #1;
            conn = t.gate && (t.code <= 5'h0b || t.code inside {[5'h18:5'h1a]});
            kd = t.code <= 5'h0b ? sar_pkg::sel_ext : t.code == 5'h18 ?
                sar_pkg::sel_opamp0 : t.code == 5'h19 ? sar_pkg::sel_opamp1 :
                sar_pkg::sel_level;
            `CHK("connect", conn, route.connect);
            if (conn)
                `CHK("kind", kd, route.kind);
            if (kd == sar_pkg::sel_ext && conn)
                `CHK("index", t.code[3:0], route.ext_index);
            `CHK("ext refs", t.rf[7:6], {route.ext_hi, route.ext_lo});
            `CHK("level", t.rf[2:0], {route.vdd_force, route.hi_level});
            `CHK("ticks", 64, ticks);
            `CHK("span", 63 * dv[t.sel], last_t - first_t);
            `CHK("irq req", 1'b1, irq_req);
            `CHK("wake", t.grn, wakes);
            rd(`OFS_MODE, d);
            `CHK("mode done", {3'b101, t.code}, d);
            rd(`OFS_RES_HI, d);
            `CHK("res hi", t.lvl[11:4], d);
            rd(`OFS_RES_LO, d);
            `CHK("res lo", {1'b0, ~t.gate, t.sel, t.lvl[3:0]}, d);
            rd(`OFS_IRQ2, d);
            `CHK("flag set", 1'b1, d[2]);
            @(posedge clk);
            irq_serviced <= 1'b1;
            @(posedge clk);
            irq_serviced <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            `CHK("irq cleared", 1'b0, irq_req);
            rd(`OFS_IRQ2, d);
            `CHK("flag clear", 1'b0, d[2]);
            wr(`OFS_MODE, {3'b100, t.code});
            rd(`OFS_MODE, d);
            `CHK("done clear", {3'b100, t.code}, d);
        end
        // pwm-triggered continuous conversion
        green_mode <= 1'b0;
        wr(`OFS_RES_LO, 8'h60);
        wr(`OFS_REF, 8'h10);
        pwm_en <= 1'b1;
        clr();
        repeat (400) @(posedge clk);
        #1;
        `CHK("pwm runs", 1'b1, samples >= 3);
        pwm_en <= 1'b0;
        repeat (200) @(posedge clk);
        clr();
        repeat (200) @(posedge clk);
        #1;
        `CHK("pwm stops", 0, samples);
        rd(`OFS_MODE, d);
        `CHK("start low", 1'b0, d[6]);
        // frozen clock enable ignores a write
        @(posedge clk);
        clk_en <= 1'b0;
        wr(`OFS_REF, 8'h00);
        clk_en <= 1'b1;
        rd(`OFS_REF, d);
        `CHK("frozen write", 8'h10, d);
        // second reset in mid-run
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(`OFS_MODE, d);
        `CHK("mode after reset", 8'h00, d);
        `CHK("power after reset", 1'b0, core_power);
        rd(`OFS_P3MASK, d);
        `CHK("mask after reset", 8'h00, d);
        end_of_test();
    end
endmodule
`default_nettype wire
